// ==== dac_host_pkg.sv ====
package dac_host_pkg;
	localparam int DATA_W = 12;
	localparam int DATA_MSB = 11;
	localparam int DATA_LSB = 0;
	localparam logic CHAN_A = 1'b0;
	localparam logic CHAN_B = 1'b1;
	localparam int CLK_PERIOD_NS = 25;
	// Write timing, ns
	localparam int T_SEL_LOW_NS = 10;
	localparam int T_SEL_HIGH_NS = 7;
	localparam int T_ADDR_SETUP_NS = 10;
	localparam int T_DATA_SETUP_NS = 6;
	localparam int T_RW_HIGH_TO_SEL_NS = 5;
	// Readback timing, ns (maxima; host waits at least this long)
	localparam int T_ACCESS_NS = 35;
	localparam int T_RELINQUISH_NS = 10;
	// Least times round up
	localparam int SEL_LOW_CYC = (T_SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEL_HIGH_CYC = (T_SEL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELINQ_CYC = (T_RELINQUISH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage

// ==== dac_host_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_host_timer #(
	parameter int W = 4
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_done
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (i_load) begin
			cnt_q <= i_count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	// Done must not look at load: the sequencer's load reads done, and the pair would form a loop
	assign o_done = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== dac_host_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channel select pin low picks channel A, high picks channel B.
// - Twelve data lines, bit 11 most significant down to bit 0.
// - Write: read/write low while select low; word captured into latch.
// - Read: read/write high while select low; device drives DAC register.
module dac_host_ctrl #(
	parameter int DATA_W = dac_host_pkg::DATA_W
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_wr_req,
	input wire logic i_rd_req,
	input wire logic i_load_req,
	input wire logic i_clear_req,
	input wire logic i_chan,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_auto_mode,
	output logic o_busy,
	output logic o_rd_valid,
	output logic [DATA_W-1:0] o_rd_data,
	input wire logic [DATA_W-1:0] i_parallel_data_bus,
	output logic [DATA_W-1:0] o_parallel_data_bus,
	output logic o_parallel_data_bus_oe,
	output logic o_dev_sel_n,
	output logic o_rd_wr_n,
	output logic o_chan_sel,
	output logic o_load_strobe_n,
	output logic o_clear_all_n
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_WLOW, ST_RLOW, ST_RELINQ, ST_SELHIGH, ST_LOAD, ST_CLEAR
	} state_e;

	state_e state_q;
	logic tmr_load;
	logic [3:0] tmr_count;
	logic tmr_done;
	logic is_read_q;

	dac_host_timer #(.W(dac_host_pkg::CNT_W)) u_timer (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_done(tmr_done)
	);

	function automatic logic [3:0] cyc(input int n);
		cyc = n[3:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sequencer; the timer is loaded on every state change except ST_SELHIGH back to ST_IDLE
	always_comb begin
		tmr_load = 1'b0;
		tmr_count = dac_host_pkg::CNT_ZERO;
		case (state_q)
			ST_IDLE: begin
				if (i_clear_req || i_load_req || i_wr_req || i_rd_req) begin
					tmr_load = 1'b1;
					tmr_count = cyc(dac_host_pkg::SETUP_CYC);
				end
			end
			ST_SETUP: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = is_read_q ? cyc(dac_host_pkg::ACCESS_CYC) : cyc(dac_host_pkg::SEL_LOW_CYC);
				end
			end
			ST_WLOW, ST_LOAD, ST_CLEAR: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = cyc(dac_host_pkg::SEL_HIGH_CYC);
				end
			end
			ST_RLOW: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = cyc(dac_host_pkg::RELINQ_CYC);
				end
			end
			ST_RELINQ: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = cyc(dac_host_pkg::SEL_HIGH_CYC);
				end
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			is_read_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (i_clear_req) begin
						state_q <= ST_CLEAR;
					end else if (i_load_req) begin
						state_q <= ST_LOAD;
					end else if (i_wr_req) begin
						state_q <= ST_SETUP;
						is_read_q <= 1'b0;
					end else if (i_rd_req) begin
						state_q <= ST_SETUP;
						is_read_q <= 1'b1;
					end
				end
				ST_SETUP: if (tmr_done) state_q <= is_read_q ? ST_RLOW : ST_WLOW;
				ST_WLOW: if (tmr_done) state_q <= ST_SELHIGH;
				ST_RLOW: if (tmr_done) state_q <= ST_RELINQ;
				ST_RELINQ: if (tmr_done) state_q <= ST_SELHIGH;
				ST_LOAD, ST_CLEAR: if (tmr_done) state_q <= ST_SELHIGH;
				ST_SELHIGH: if (tmr_done) state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_dev_sel_n <= 1'b1;
			o_rd_wr_n <= 1'b1;
			o_chan_sel <= dac_host_pkg::CHAN_A;
			o_parallel_data_bus <= '0;
			o_parallel_data_bus_oe <= 1'b0;
		end else if (state_q == ST_IDLE && (i_wr_req || i_rd_req) && !i_clear_req && !i_load_req) begin
			o_chan_sel <= i_chan;
			// Read/write settles before select falls
			o_rd_wr_n <= !i_wr_req;
			o_parallel_data_bus <= i_wr_data;
			o_parallel_data_bus_oe <= i_wr_req;
		end else if (state_q == ST_SETUP && tmr_done) begin
			o_dev_sel_n <= 1'b0;
		end else if ((state_q == ST_WLOW || state_q == ST_RLOW) && tmr_done) begin
			// Data and read/write held past the rising edge where the device latches
			o_dev_sel_n <= 1'b1;
		end else if (state_q == ST_SELHIGH && tmr_done) begin
			o_parallel_data_bus_oe <= 1'b0;
			o_rd_wr_n <= 1'b1;
		end
	end

	// Strobe low in auto mode; otherwise a timed low pulse
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_load_strobe_n <= 1'b1;
		end else if (i_auto_mode) begin
			o_load_strobe_n <= 1'b0;
		end else if (state_q == ST_IDLE && i_load_req && !i_clear_req) begin
			o_load_strobe_n <= 1'b0;
		end else if (state_q == ST_LOAD && tmr_done) begin
			o_load_strobe_n <= 1'b1;
		end else if (state_q != ST_LOAD) begin
			o_load_strobe_n <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_clear_all_n <= 1'b1;
		end else if (state_q == ST_IDLE && i_clear_req) begin
			o_clear_all_n <= 1'b0;
		end else if (state_q == ST_CLEAR && tmr_done) begin
			o_clear_all_n <= 1'b1;
		end
	end

	// Readback sampled at end of access window, before select rises
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rd_data <= '0;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			if (state_q == ST_RLOW && tmr_done) begin
				o_rd_data <= i_parallel_data_bus;
				o_rd_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= !(state_q == ST_IDLE && !(i_clear_req || i_load_req || i_wr_req || i_rd_req))
				&& !(state_q == ST_SELHIGH && tmr_done);
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_no_drive_in_read;
		@(posedge i_mclk) disable iff (i_rst) (o_rd_wr_n && !o_dev_sel_n) |-> !o_parallel_data_bus_oe;
	endproperty
	a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("host drives bus during readback");

	property p_data_stable_at_latch;
		@(posedge i_mclk) disable iff (i_rst) ($rose(o_dev_sel_n) && !o_rd_wr_n)
			|-> ($stable(o_parallel_data_bus) && o_parallel_data_bus_oe && $stable(o_chan_sel));
	endproperty
	a_data_stable_at_latch: assert property (p_data_stable_at_latch) else $error("write data moved at latch edge");

	property p_write_drives;
		@(posedge i_mclk) disable iff (i_rst) (!o_dev_sel_n && !o_rd_wr_n) |-> o_parallel_data_bus_oe;
	endproperty
	a_write_drives: assert property (p_write_drives) else $error("write without bus drive");

	property p_rw_stable_in_sel;
		@(posedge i_mclk) disable iff (i_rst) (!o_dev_sel_n && !$past(o_dev_sel_n)) |-> $stable(o_rd_wr_n);
	endproperty
	a_rw_stable_in_sel: assert property (p_rw_stable_in_sel) else $error("read/write changed while selected");

	property p_clear_pulse_ends;
		@(posedge i_mclk) disable iff (i_rst) $fell(o_clear_all_n) |-> ##[1:4] o_clear_all_n;
	endproperty
	a_clear_pulse_ends: assert property (p_clear_pulse_ends) else $error("clear pulse stuck");

	property p_load_pulse_ends;
		@(posedge i_mclk) disable iff (i_rst) ($fell(o_load_strobe_n) && !i_auto_mode) |-> ##[1:4] (o_load_strobe_n || i_auto_mode);
	endproperty
	a_load_pulse_ends: assert property (p_load_pulse_ends) else $error("load pulse stuck");

	property p_auto_low;
		@(posedge i_mclk) disable iff (i_rst) i_auto_mode |=> !o_load_strobe_n;
	endproperty
	a_auto_low: assert property (p_auto_low) else $error("strobe high in auto mode");

	property p_rd_valid_in_read;
		@(posedge i_mclk) disable iff (i_rst) o_rd_valid |-> ($past(o_rd_wr_n) && !$past(o_dev_sel_n));
	endproperty
	a_rd_valid_in_read: assert property (p_rd_valid_in_read) else $error("read data outside readback");
endmodule
`default_nettype wire

// ==== dac_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_dev_model (
	input wire logic [11:0] i_bus,
	input wire logic i_sel_n,
	input wire logic i_rd_wr_n,
	input wire logic i_chan,
	input wire logic i_load_n,
	input wire logic i_clear_n,
	output logic [11:0] o_bus,
	output logic o_oe,
	output logic [11:0] o_dac_a,
	output logic [11:0] o_dac_b
);
	logic [11:0] lat_a = 12'h000;
	logic [11:0] lat_b = 12'h000;
	logic sel_p = 1'b1;
	logic load_p = 1'b1;
	logic [11:0] dac_a = 12'h000;
	logic [11:0] dac_b = 12'h000;
	////////////////////////////////////////////////////////////
	// No clock: pin edges are found by comparing with the last level seen
	always @(i_sel_n, i_load_n, i_clear_n) begin
		if (!i_clear_n) begin
			lat_a = 12'h000;
			lat_b = 12'h000;
			dac_a = 12'h000;
			dac_b = 12'h000;
		end else begin
			if (i_sel_n && !sel_p && !i_rd_wr_n) begin
				if (i_chan) lat_b = i_bus;
				else lat_a = i_bus;
				if (!i_load_n) begin
					dac_a = lat_a;
					dac_b = lat_b;
				end
			end
			if (!i_load_n && load_p) begin
				dac_a = lat_a;
				dac_b = lat_b;
			end
		end
		sel_p = i_sel_n;
		load_p = i_load_n;
	end
	assign o_dac_a = dac_a;
	assign o_dac_b = dac_b;
	assign o_oe = !i_sel_n && i_rd_wr_n;
	// Released bus shows the inverse, so a stale word never passes for a good one
	assign o_bus = (i_chan ? o_dac_b : o_dac_a) ^ {12{!o_oe}};
endmodule
`default_nettype wire

// ==== dual_dac_parallel_load_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dual_dac_parallel_load_port_tb_top;
	typedef struct packed {
		logic [1:0] op;
		logic chan;
		logic [11:0] data;
		logic auto;
		logic [11:0] exp_a;
		logic [11:0] exp_b;
	} row_s;
	logic i_mclk = 1'b0;
	logic rst, wr, rd, ld, cl, chan, auto, busy, rv, hoe, sel_n, rw_n, csel, ld_n, cl_n, doe;
	logic [11:0] wdata, rdata, hbus, bus, dbus, da, db, got;
	int errors = 0;
	int total_checks = 0;
	// Ops: 0 write, 1 read (data is the expected word), 2 load, 3 clear
	row_s rows [10] = '{
		'{2'h0, 1'b0, 12'hABC, 1'b0, 12'h000, 12'h000},
		'{2'h0, 1'b1, 12'h123, 1'b0, 12'h000, 12'h000},
		'{2'h2, 1'b0, 12'h000, 1'b0, 12'hABC, 12'h123},
		'{2'h1, 1'b0, 12'hABC, 1'b0, 12'hABC, 12'h123},
		'{2'h1, 1'b1, 12'h123, 1'b0, 12'hABC, 12'h123},
		'{2'h0, 1'b0, 12'h800, 1'b1, 12'h800, 12'h123},
		'{2'h0, 1'b1, 12'h001, 1'b1, 12'h800, 12'h001},
		'{2'h1, 1'b1, 12'h001, 1'b0, 12'h800, 12'h001},
		'{2'h3, 1'b0, 12'h000, 1'b0, 12'h000, 12'h000},
		'{2'h1, 1'b0, 12'h000, 1'b0, 12'h000, 12'h000}};
	row_s rd_a = '{2'h1, 1'b0, 12'hFFF, 1'b0, 12'hFFF, 12'h000};
	always #12.5 i_mclk = ~i_mclk;
	assign bus = hoe ? hbus : dbus;
	dac_host_ctrl dut (.i_mclk(i_mclk), .i_rst(rst), .i_wr_req(wr), .i_rd_req(rd), .i_load_req(ld),
		.i_clear_req(cl), .i_chan(chan), .i_wr_data(wdata), .i_auto_mode(auto), .o_busy(busy),
		.o_rd_valid(rv), .o_rd_data(rdata), .i_parallel_data_bus(bus), .o_parallel_data_bus(hbus),
		.o_parallel_data_bus_oe(hoe), .o_dev_sel_n(sel_n), .o_rd_wr_n(rw_n), .o_chan_sel(csel),
		.o_load_strobe_n(ld_n), .o_clear_all_n(cl_n));
	dac_dev_model dev (.i_bus(bus), .i_sel_n(sel_n), .i_rd_wr_n(rw_n), .i_chan(csel), .i_load_n(ld_n),
		.i_clear_n(cl_n), .o_bus(dbus), .o_oe(doe), .o_dac_a(da), .o_dac_b(db));
	////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task end_of_test;
		if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task run(input row_s r);
		@(posedge i_mclk);
		wr <= (r.op == 2'h0);
		rd <= (r.op == 2'h1);
		ld <= (r.op == 2'h2);
		cl <= (r.op == 2'h3);
		chan <= r.chan;
		wdata <= r.data;
		auto <= r.auto;
		@(posedge i_mclk);
		{wr, rd, ld, cl} <= 4'h0;
		for (int i = 0; i < 30; i++) begin
			@(posedge i_mclk);
			#1;
			if (rv === 1'b1) got = rdata;
			if (busy === 1'b0 && i > 2) break;
		end
		// A sequence that never ends runs the loop out and shows up here
		chk("busy_end", 12'h000, {11'h000, busy});
	endtask
	////////////////////////////////////////////////////////////
	always @(posedge i_mclk) if (hoe === 1'b1 && doe === 1'b1) begin
		errors++;
		$display("CHECK FAILED bus_contention exp 0 got 1");
	end
	initial begin
		{rst, wr, rd, ld, cl, chan, auto} = 7'h40;
		wdata = 12'h000;
		repeat (6) @(posedge i_mclk);
		rst <= 1'b0;
		@(posedge i_mclk);
		#1;
		chk("idle_pins", 12'h00E, {8'h00, sel_n, ld_n, cl_n, hoe});
		foreach (rows[k]) begin
			run(rows[k]);
			if (rows[k].op == 2'h1) chk("readback", rows[k].data, got);
			chk("dac_a", rows[k].exp_a, da);
			chk("dac_b", rows[k].exp_b, db);
		end
		// A second write while busy must be dropped, not queued
		@(posedge i_mclk);
		{wr, chan, auto} <= 3'h5;
		wdata <= 12'hFFF;
		@(posedge i_mclk);
		wr <= 1'b0;
		@(posedge i_mclk);
		wr <= 1'b1;
		wdata <= 12'h555;
		@(posedge i_mclk);
		wr <= 1'b0;
		for (int i = 0; i < 30 && busy !== 1'b0; i++) begin
			@(posedge i_mclk);
			#1;
		end
		// Wait long enough that a queued second write would have landed
		repeat (12) @(posedge i_mclk);
		#1;
		chk("dropped_write_busy", 12'h000, {11'h000, busy});
		chk("dropped_write", 12'hFFF, da);
		// Reset in mid-write frees every pin at once; with the strobe high the DAC keeps its code
		@(posedge i_mclk);
		{wr, auto} <= 2'h2;
		wdata <= 12'h0F0;
		@(posedge i_mclk);
		wr <= 1'b0;
		repeat (2) @(posedge i_mclk);
		rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		rst <= 1'b0;
		@(posedge i_mclk);
		#1;
		chk("reset_pins", 12'h00E, {7'h00, busy, sel_n, ld_n, cl_n, hoe});
		chk("reset_dac_a", 12'hFFF, da);
		run(rd_a);
		chk("readback_after_reset", 12'hFFF, got);
		end_of_test();
	end
	// About 130 cycles expected; the margin covers slow sequences
	initial begin
		#(25 * 4000);
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
